// ==== hdl/rpi_pkg.sv ====
// Purpose: constants and carrier types for the rtc prescaler/interrupt block
// Assumes: pclk at 20 MHz, 32.768 kHz oscillator arriving on a pin
// Notes: register words are overlaid by packed structs, bit 0 last
//
// Overview of operation
// - countdown pulse width follows source and value
// - countdown value zero keeps timer stopped
// - clearing flag ends its pulse at once
// - level minute/second irq released by disables
// - watchdog irq level gated by control field
// - watchdog flag read only, writes ignored
// - alarm irq follows alarm flag as level
// - stamp irq follows stamp flags as level
// - switchover irq follows its flag as level
// - battery low irq follows read-only flag
// - test bit turns clock pin into input
// - test mode: 64 pin edges per second
// - stop bit holds prescaler top at zero
// - after stop, first second after 32 edges
// - stop suppresses second ticks, time frozen
// - stop leaves clock output running
// - lower nine stages run while stopped
// - time advances on top stage rising
// - first stage clocked by 32.768 kHz oscillator
// - pulse select picks pulse or level minute/second and countdown irqs
// - interrupt pin open drain, released when idle
// - minute/second pulse lasts one 64 Hz period
package rpi_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_TIMER = 8'h0c;
    localparam logic [7:0] ADDR_TIME = 8'h10;
    localparam logic [7:0] ADDR_PRESC = 8'h14;

    // ------------------------------------------------------------------
    // prescaler and timing constants
    // ------------------------------------------------------------------
    localparam int OSC_HZ = 32768; // oscillator rate
    localparam int LOW_W = 9; // stages F0..F8
    localparam int UP_W = 6; // stages F9..F14
    localparam int DIV_4096_BITS = 3; // 32768 / 2**3 = 4096 Hz
    localparam int PW_W = 10; // pulse counter width
    localparam int PW_4096_N1_DEN = 8192; // 1/8192 s
    localparam int PW_4096_DEN = 4096; // 1/4096 s
    localparam int PW_64_N1_DEN = 128; // 1/128 s
    localparam int PW_SLOW_DEN = 64; // 1/64 s
    // pulse widths counted in oscillator edges
    localparam logic [PW_W-1:0] PW_4096_N1 = PW_W'(OSC_HZ / PW_4096_N1_DEN);
    localparam logic [PW_W-1:0] PW_4096 = PW_W'(OSC_HZ / PW_4096_DEN);
    localparam logic [PW_W-1:0] PW_64_N1 = PW_W'(OSC_HZ / PW_64_N1_DEN);
    localparam logic [PW_W-1:0] PW_SLOW = PW_W'(OSC_HZ / PW_SLOW_DEN);
    localparam logic [5:0] SEC_LAST = 6'h3b; // 59 seconds/minutes

    // ------------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SRC_4096, SRC_64, SRC_1, SRC_60TH} rpi_src_e;

    typedef struct packed {
        logic [24:0] rsvd;
        logic [1:0] wd_ctl; // watchdog_ctl_field
        logic pulse_sel; // timer_irq_pulse_sel
        logic sec_en; // second interrupt enable
        logic min_en; // minute_irq_en
        logic test_en; // ext_clock_test_en
        logic stop;
    } rpi_ctrl_s;

    typedef struct packed {
        logic [26:0] rsvd;
        logic batt_low; // batt_low_irq_en
        logic switchover; // switchover_irq_en
        logic stamp; // stamp_irq_en
        logic alarm; // alarm_irq_en
        logic countdown; // countdown irq enable
    } rpi_irq_en_s;

    typedef struct packed {
        logic [22:0] rsvd;
        logic int_active;
        logic batt_low; // batt_low_flag, read only
        logic switchover; // switchover_flag
        logic [1:0] stamp; // stamp_flags
        logic alarm; // alarm_flag
        logic watchdog; // watchdog_flag, read only
        logic countdown; // countdown_flag
        logic min_sec; // min_sec_flag
    } rpi_flags_s;

    typedef struct packed {
        logic [21:0] rsvd;
        rpi_src_e src;
        logic [7:0] value;
    } rpi_timer_s;

    typedef struct packed {
        logic [19:0] rsvd;
        logic [5:0] minutes;
        logic [5:0] seconds;
    } rpi_time_s;

    // whole state of the block
    typedef struct packed {
        logic [1:0] sync_osc;
        logic osc_d;
        logic [1:0] sync_ext;
        logic ext_d;
        logic [LOW_W-1:0] lower;
        logic [UP_W-1:0] upper;
        rpi_ctrl_s ctrl;
        rpi_irq_en_s irq_en;
        rpi_flags_s flags;
        rpi_timer_s timer;
        rpi_time_s time_cnt;
        logic [7:0] cd_count;
        logic [PW_W-1:0] cd_pw;
        logic [PW_W-1:0] ms_pw;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic int_oe;
        logic int_n;
        logic clk_out;
        logic clk_oe;
    } rpi_state_s;

endpackage

// ==== hdl/rpi_core.sv ====
// Purpose: prescaler, countdown and interrupt pin logic behind an APB slave
// Assumes: flag inputs come from logic on pclk; osc and clock pin are async
// Notes: zero wait state APB; all outputs registered
`timescale 1ns/1ps
`default_nettype none
module rpi_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_clk,
    input wire logic clock_out_pin_i,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe,
    input wire logic watchdog_flag,
    input wire logic batt_low_flag,
    input wire logic alarm_set,
    input wire logic [1:0] stamp_set,
    input wire logic switchover_set,
    output logic int_n_o,
    output logic int_n_oe
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // picks the countdown source tick
    function automatic logic src_tick(input rpi_pkg::rpi_src_e src,
                                      input logic t4096, input logic t64,
                                      input logic t1, input logic t60);
        unique case (src)
            rpi_pkg::SRC_4096: return t4096;
            rpi_pkg::SRC_64: return t64;
            rpi_pkg::SRC_1: return t1;
            rpi_pkg::SRC_60TH: return t60;
        endcase
    endfunction

    // countdown pulse width in oscillator edges
    function automatic logic [rpi_pkg::PW_W-1:0] cd_width(
            input rpi_pkg::rpi_src_e src, input logic n_is_one);
        unique case (src)
            rpi_pkg::SRC_4096:
                return n_is_one ? rpi_pkg::PW_4096_N1 : rpi_pkg::PW_4096;
            rpi_pkg::SRC_64:
                return n_is_one ? rpi_pkg::PW_64_N1 : rpi_pkg::PW_SLOW;
            rpi_pkg::SRC_1, rpi_pkg::SRC_60TH: return rpi_pkg::PW_SLOW;
        endcase
    endfunction

    rpi_pkg::rpi_state_s st; // registered state
    rpi_pkg::rpi_state_s next_st; // next state
    logic osc_tick; // synced oscillator rising edge
    logic ext_tick; // synced clock pin rising edge
    logic base_tick; // 64 Hz base into F9
    logic sec_tick; // F14 rising
    logic min_tick; // minute rollover
    logic ms_evt; // minute/second flag event
    logic cd_evt; // countdown period end
    logic setup; // apb setup cycle
    logic wr; // apb write completes
    logic [4:0] req; // per-source requests

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // first flop only feeds the second
        next_st.sync_osc = {st.sync_osc[0], osc_clk};
        next_st.osc_d = st.sync_osc[1];
        next_st.sync_ext = {st.sync_ext[0], clock_out_pin_i};
        next_st.ext_d = st.sync_ext[1];
        osc_tick = st.sync_osc[1] & ~st.osc_d;
        ext_tick = st.sync_ext[1] & ~st.ext_d;

        // lower stages never stop, so clock out is untouched by stop
        if (osc_tick) begin
            next_st.lower = st.lower + 9'h001;
        end
        // pin edges replace the internal 64 Hz base in test mode
        if (st.ctrl.test_en) begin
            base_tick = ext_tick;
        end else begin
            base_tick = osc_tick & (&st.lower);
        end
        if (st.ctrl.stop) begin
            next_st.upper = '0;
        end else if (base_tick) begin
            next_st.upper = st.upper + 6'h01;
        end
        sec_tick = next_st.upper[rpi_pkg::UP_W-1] &
                   ~st.upper[rpi_pkg::UP_W-1];
        min_tick = sec_tick & (st.time_cnt.seconds == rpi_pkg::SEC_LAST);

        // time counters
        if (sec_tick) begin
            if (st.time_cnt.seconds == rpi_pkg::SEC_LAST) begin
                next_st.time_cnt.seconds = '0;
                if (st.time_cnt.minutes == rpi_pkg::SEC_LAST) begin
                    next_st.time_cnt.minutes = '0;
                end else begin
                    next_st.time_cnt.minutes = st.time_cnt.minutes + 6'h01;
                end
            end else begin
                next_st.time_cnt.seconds = st.time_cnt.seconds + 6'h01;
            end
        end

        // countdown: a zero value holds it idle with no events
        cd_evt = 1'b0;
        if (st.timer.value == 8'h00) begin
            next_st.cd_count = '0;
        end else if (src_tick(st.timer.src,
                osc_tick & (&st.lower[rpi_pkg::DIV_4096_BITS-1:0]),
                              base_tick, sec_tick, min_tick)) begin
            if (st.cd_count <= 8'h01) begin
                next_st.cd_count = st.timer.value;
                cd_evt = 1'b1;
            end else begin
                next_st.cd_count = st.cd_count - 8'h01;
            end
        end

        // apb: answer is registered in setup, write lands at completion
        setup = psel & ~penable;
        wr = psel & penable & st.pready & pwrite;
        next_st.pready = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata = '0;
        if (setup & ~pwrite) begin
            unique case (paddr)
                rpi_pkg::ADDR_CTRL: next_st.prdata = st.ctrl;
                rpi_pkg::ADDR_IRQ_EN: next_st.prdata = st.irq_en;
                rpi_pkg::ADDR_FLAGS: next_st.prdata = st.flags;
                rpi_pkg::ADDR_TIMER: next_st.prdata = st.timer;
                rpi_pkg::ADDR_TIME: next_st.prdata = st.time_cnt;
                rpi_pkg::ADDR_PRESC:
                    next_st.prdata = 32'(({st.upper, st.lower}));
                default: next_st.pslverr = 1'b1;
            endcase
        end else if (setup) begin
            unique case (paddr)
                rpi_pkg::ADDR_CTRL, rpi_pkg::ADDR_IRQ_EN, rpi_pkg::ADDR_FLAGS,
                rpi_pkg::ADDR_TIMER, rpi_pkg::ADDR_TIME,
                rpi_pkg::ADDR_PRESC: next_st.pslverr = 1'b0;
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                rpi_pkg::ADDR_CTRL: begin
                    next_st.ctrl = rpi_pkg::rpi_ctrl_s'(pwdata);
                    next_st.ctrl.rsvd = '0;
                end
                rpi_pkg::ADDR_IRQ_EN: begin
                    next_st.irq_en = rpi_pkg::rpi_irq_en_s'(pwdata);
                    next_st.irq_en.rsvd = '0;
                end
                rpi_pkg::ADDR_FLAGS: begin
                    // write one to clear; watchdog and battery low ignore it
                    next_st.flags.min_sec = st.flags.min_sec & ~pwdata[0];
                    next_st.flags.countdown = st.flags.countdown & ~pwdata[1];
                    next_st.flags.alarm = st.flags.alarm & ~pwdata[3];
                    next_st.flags.stamp = st.flags.stamp & ~pwdata[5:4];
                    next_st.flags.switchover = st.flags.switchover &
                                               ~pwdata[6];
                end
                rpi_pkg::ADDR_TIMER: begin
                    next_st.timer = rpi_pkg::rpi_timer_s'(pwdata);
                    next_st.timer.rsvd = '0;
                    next_st.cd_count = pwdata[7:0]; // reload on write
                end
                rpi_pkg::ADDR_TIME: begin
                    next_st.time_cnt = rpi_pkg::rpi_time_s'(pwdata);
                    next_st.time_cnt.rsvd = '0;
                end
                default: ; // read-only or unmapped: ignored
            endcase
        end

        // events after clears, so a set in the clear cycle wins
        ms_evt = st.ctrl.sec_en ? sec_tick : (st.ctrl.min_en & min_tick);
        next_st.flags.min_sec = next_st.flags.min_sec | ms_evt;
        next_st.flags.countdown = next_st.flags.countdown | cd_evt;
        next_st.flags.alarm = next_st.flags.alarm | alarm_set;
        next_st.flags.stamp = next_st.flags.stamp | stamp_set;
        next_st.flags.switchover = next_st.flags.switchover | switchover_set;
        next_st.flags.watchdog = watchdog_flag;
        next_st.flags.batt_low = batt_low_flag;

        // pulse timers run on oscillator edges
        if (osc_tick && st.ms_pw != '0) begin
            next_st.ms_pw = st.ms_pw - 10'h001;
        end
        if (osc_tick && st.cd_pw != '0) begin
            next_st.cd_pw = st.cd_pw - 10'h001;
        end
        if (ms_evt) begin
            next_st.ms_pw = rpi_pkg::PW_SLOW;
        end
        if (cd_evt) begin
            next_st.cd_pw = cd_width(st.timer.src,
                                     st.timer.value == 8'h01);
        end
        // a cleared flag cuts its pulse short
        if (!next_st.flags.min_sec) begin
            next_st.ms_pw = '0;
        end
        if (!next_st.flags.countdown) begin
            next_st.cd_pw = '0;
        end

        // per-source requests from the new flag values
        if (next_st.ctrl.pulse_sel) begin
            req[0] = (next_st.ms_pw != '0) &
                     (next_st.ctrl.min_en | next_st.ctrl.sec_en);
            req[1] = (next_st.cd_pw != '0) & next_st.irq_en.countdown;
        end else begin
            req[0] = next_st.flags.min_sec &
                     (next_st.ctrl.min_en | next_st.ctrl.sec_en);
            req[1] = next_st.flags.countdown & next_st.irq_en.countdown;
        end
        req[2] = (|next_st.ctrl.wd_ctl) & watchdog_flag;
        req[3] = (next_st.irq_en.alarm & next_st.flags.alarm) |
                 (next_st.irq_en.stamp & (|next_st.flags.stamp));
        req[4] = (next_st.irq_en.switchover &
                  next_st.flags.switchover) |
                 (next_st.irq_en.batt_low & batt_low_flag);
        // open drain: pull low only while a request stands
        next_st.int_oe = |req;
        next_st.int_n = ~(|req);
        next_st.flags.int_active = |req;
        // clock pin is an input in test mode; stop does not touch it
        next_st.clk_out = next_st.lower[0];
        next_st.clk_oe = ~next_st.ctrl.test_en;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.int_n <= 1'b1;
            st.clk_oe <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign clock_out_pin_o = st.clk_out;
    assign clock_out_pin_oe = st.clk_oe;
    assign int_n_o = st.int_n;
    assign int_n_oe = st.int_oe;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [6:0] chk_base_cnt; // base ticks since last second or stop
    logic chk_first; // next second is the first after stop/reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_base_cnt <= '0;
            chk_first <= 1'b1;
        end else if (st.ctrl.stop) begin
            chk_base_cnt <= '0;
            chk_first <= 1'b1;
        end else if (sec_tick) begin
            chk_base_cnt <= '0;
            chk_first <= 1'b0;
        end else if (base_tick) begin
            chk_base_cnt <= chk_base_cnt + 7'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stop_held;
        st.ctrl.stop ##1 st.ctrl.stop;
    endsequence
    sequence s_cd_start;
        cd_evt ##1 (st.flags.countdown && st.irq_en.countdown);
    endsequence

    chk_stop_zeroes: assert property (s_stop_held |->
            st.upper == '0)
        else $error("prescaler top not held at zero by stop");

    chk_stop_no_tick: assert property (st.ctrl.stop |-> !sec_tick)
        else $error("second tick while stopped");

    // first second after 32 base ticks, then every 64
    chk_first_second: assert property (sec_tick |->
            (chk_first ? chk_base_cnt == 7'd31 : chk_base_cnt == 7'd63))
        else $error("second tick after wrong number of base ticks");

    chk_cd_zero: assert property (st.timer.value == 8'h00 |-> !cd_evt)
        else $error("countdown fired with zero value");

    chk_cd_pulse: assert property (s_cd_start ##0 st.ctrl.pulse_sel |->
            st.int_oe && st.cd_pw != '0)
        else $error("countdown pulse not driven");

    chk_pulse_cut: assert property ($fell(st.flags.min_sec) |->
            st.ms_pw == '0)
        else $error("pulse outlived its cleared flag");

    chk_cd_cut: assert property ($fell(st.flags.countdown) |->
            st.cd_pw == '0)
        else $error("countdown pulse outlived its flag");

    chk_wd_level: assert property ((|st.ctrl.wd_ctl) &&
            $past(watchdog_flag) |-> st.int_oe && !st.int_n)
        else $error("watchdog request not on pin");

    chk_alarm_rel: assert property (st.irq_en.alarm && st.flags.alarm |->
            st.int_oe && !st.int_n)
        else $error("alarm flag not on pin");

    chk_idle_hiz: assert property (st.irq_en == '0 &&
            st.ctrl.wd_ctl == 2'b00 && !st.ctrl.min_en &&
            !st.ctrl.sec_en |-> !st.int_oe)
        else $error("pin driven with all sources off");

    chk_test_input: assert property (st.ctrl.test_en &&
            $past(st.ctrl.test_en) |-> !clock_out_pin_oe)
        else $error("clock pin driven in test mode");

endmodule // rpi_core
`default_nettype wire

// ==== hdl/rpi_core_note_unused.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== test/rpi_host.sv ====
// Purpose: host side of the open-drain interrupt line
// Assumes: a board pull-up holds the line high when released
// Notes: the host only watches the resolved level
`timescale 1ns/1ps
`default_nettype none
module rpi_host (
    input wire logic int_n_o,
    input wire logic int_n_oe,
    output logic int_line
);
    // ------------------------------------------------------------------
    // wire level
    // ------------------------------------------------------------------
    // released line floats up to the pull-up, never to a stale value
    assign int_line = int_n_oe ? int_n_o : 1'b1;
endmodule // rpi_host
`default_nettype wire

// ==== test/rtc_prescaler_interrupt_logic_test.sv ====
// Purpose: register-level test of the prescaler and interrupt block
// Assumes: APB at 20 MHz; oscillator sped up to 1 MHz to keep runs short
// Notes: pulse widths are judged in oscillator periods, not seconds
`timescale 1ns/1ps
`default_nettype none
module rtc_prescaler_interrupt_logic_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic osc_clk, ext_clk, pin_i, pin_o, pin_oe, pin_prev;
    logic int_n_o, int_n_oe, int_line, wd_flag, bl_flag, al_set, sw_set;
    logic [1:0] st_set;
    logic [4:0] oc; // oscillator divider
    logic [31:0] en_tab [3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0008};
    logic [31:0] fl_tab [3] = '{32'h0000_0008, 32'h0000_0030, 32'h0000_0040};
    int n_errors, checked, cyc;

    // ------------------------------------------------------------------
    // clocks and pins
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // oscillator: one period every 20 pclk, slow enough for the syncs
    always @(posedge pclk) begin
        oc <= (oc == 5'h09) ? 5'h00 : oc + 5'h01;
        if (oc == 5'h09) begin
            osc_clk <= ~osc_clk;
        end
    end
    // clock pin: device drives it unless in test mode
    assign pin_i = pin_oe ? pin_o : ext_clk;

    rpi_core u_rpi_core (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_clk(osc_clk), .clock_out_pin_i(pin_i),
        .clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe),
        .watchdog_flag(wd_flag), .batt_low_flag(bl_flag),
        .alarm_set(al_set), .stamp_set(st_set),
        .switchover_set(sw_set), .int_n_o(int_n_o), .int_n_oe(int_n_oe));
    rpi_host u_rpi_host (.int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .int_line(int_line));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            summarize();
        end
    endtask
    // waits for a low pulse on the line and measures it in pclk
    task automatic width(output int w);
        int n;
        n = 0;
        w = 0;
        while (int_line !== 1'b0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        while (int_line === 1'b0 && w < 3000) begin
            @(posedge pclk);
            w++;
        end
        if (n >= 3000 || w >= 3000) begin
            chk(32'h0, 32'h1);
            summarize();
        end
    endtask
    // test clock edges, each level four pclk wide
    task automatic pulses(input int k);
        repeat (k) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, osc_clk, ext_clk} = 6'h00;
        {wd_flag, bl_flag, al_set, sw_set, st_set} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        oc = 5'h00;
        n_errors = 0;
        checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rpi_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(32'(int_line), 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(er), 32'h1);
        $display("reset and map test done");
        // level sources: alarm, stamp, switchover
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, rpi_pkg::ADDR_IRQ_EN, en_tab[k]);
            al_set <= (k == 0);
            st_set <= {2{k == 1}};
            sw_set <= (k == 2);
            @(posedge pclk);
            {al_set, st_set, sw_set} <= 4'h0;
            repeat (3) @(posedge pclk);
            chk(32'(int_line), 32'h0);
            apb(1'b1, rpi_pkg::ADDR_FLAGS, fl_tab[k]);
            @(posedge pclk);
            chk(32'(int_line), 32'h1);
        end
        apb(1'b1, rpi_pkg::ADDR_IRQ_EN, 32'h0);
        $display("level source test done");
        // watchdog gated by its field, flag not clearable
        wd_flag <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(int_line), 32'h1);
        apb(1'b1, rpi_pkg::ADDR_CTRL, 32'h0000_0020);
        apb(1'b1, rpi_pkg::ADDR_FLAGS, 32'h0000_0004);
        apb(1'b0, rpi_pkg::ADDR_FLAGS, 32'h0);
        chk(rd & 32'h0000_0004, 32'h0000_0004);
        chk(32'(int_line), 32'h0);
        wd_flag <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(int_line), 32'h1);
        // battery low released only by its enable
        bl_flag <= 1'b1;
        apb(1'b1, rpi_pkg::ADDR_IRQ_EN, 32'h0000_0010);
        apb(1'b1, rpi_pkg::ADDR_FLAGS, 32'h0000_0080);
        @(posedge pclk);
        chk(32'(int_line), 32'h0);
        apb(1'b1, rpi_pkg::ADDR_IRQ_EN, 32'h0);
        @(posedge pclk);
        chk(32'(int_line), 32'h1);
        bl_flag <= 1'b0;
        $display("watchdog and battery test done");
        // countdown pulses at 4096 Hz: 4 then 8 oscillator periods
        apb(1'b1, rpi_pkg::ADDR_CTRL, 32'h0000_0010);
        apb(1'b1, rpi_pkg::ADDR_IRQ_EN, 32'h0000_0001);
        for (int n = 1; n < 3; n++) begin
            apb(1'b1, rpi_pkg::ADDR_TIMER, 32'(n));
            width(cyc);
            width(cyc);
            chk(32'((cyc + 10) / 20), 32'(4 * n));
        end
        // clearing the flag cuts the pulse short
        width(cyc);
        cyc = 0;
        while (int_line !== 1'b0 && cyc < 3000) begin
            @(posedge pclk);
            cyc++;
        end
        chk(32'(int_line), 32'h0);
        if (cyc >= 3000) summarize();
        apb(1'b1, rpi_pkg::ADDR_FLAGS, 32'h0000_0002);
        @(posedge pclk);
        chk(32'(int_line), 32'h1);
        // zero value keeps the timer silent
        apb(1'b1, rpi_pkg::ADDR_TIMER, 32'h0);
        repeat (200) @(posedge pclk);
        cyc = 0;
        repeat (600) begin
            @(posedge pclk);
            cyc += (int_line === 1'b0);
        end
        chk(32'(cyc), 32'h0);
        apb(1'b1, rpi_pkg::ADDR_IRQ_EN, 32'h0);
        $display("countdown test done");
        // stop leaves the clock output running
        apb(1'b1, rpi_pkg::ADDR_CTRL, 32'h0000_0001);
        cyc = 0;
        pin_prev = pin_o;
        repeat (200) begin
            @(posedge pclk);
            cyc += (pin_o !== pin_prev);
            pin_prev = pin_o;
        end
        chk(32'(cyc > 5 && pin_oe === 1'b1), 32'h1);
        // test mode: set then clear stop before counting edges
        apb(1'b1, rpi_pkg::ADDR_CTRL, 32'h0000_0003);
        @(posedge pclk);
        chk(32'(pin_oe), 32'h0);
        apb(1'b1, rpi_pkg::ADDR_TIME, 32'h0);
        apb(1'b0, rpi_pkg::ADDR_PRESC, 32'h0);
        chk(32'(rd[14:9]), 32'h0);
        apb(1'b1, rpi_pkg::ADDR_CTRL, 32'h0000_000a);
        pulses(31);
        apb(1'b0, rpi_pkg::ADDR_TIME, 32'h0);
        chk(rd, 32'h0);
        pulses(1);
        apb(1'b0, rpi_pkg::ADDR_TIME, 32'h0);
        chk(rd, 32'h1);
        chk(32'(int_line), 32'h0);
        pulses(63);
        apb(1'b0, rpi_pkg::ADDR_TIME, 32'h0);
        chk(rd, 32'h1);
        pulses(1);
        apb(1'b0, rpi_pkg::ADDR_TIME, 32'h0);
        chk(rd, 32'h2);
        // stop freezes the time counters
        apb(1'b1, rpi_pkg::ADDR_CTRL, 32'h0000_0003);
        pulses(64);
        apb(1'b0, rpi_pkg::ADDR_TIME, 32'h0);
        chk(rd, 32'h2);
        chk(32'(int_line), 32'h1);
        $display("test mode and stop test done");
        summarize();
    end
endmodule // rtc_prescaler_interrupt_logic_test
`default_nettype wire
